// File: src/pcxb_pkg.sv
// Shared constants for the priority crossbar port configuration block
package pcxb_pkg;
  localparam int NXPIN = 32;
  localparam int NPIN = 40;
  localparam int NPORT = 5;
  localparam int NSIG = 23;
  localparam int NREG = 22;
  localparam int REG_SEL_W = 5;

  // Peripheral signals in crossbar priority order
  localparam int SIG_U0_TX = 0;
  localparam int SIG_U0_RX = 1;
  localparam int SIG_SPI_SCK = 2;
  localparam int SIG_SPI_MISO = 3;
  localparam int SIG_SPI_MOSI = 4;
  localparam int SIG_SPI_NSS = 5;
  localparam int SIG_SMB_SDA = 6;
  localparam int SIG_SMB_SCL = 7;
  localparam int SIG_CP0 = 8;
  localparam int SIG_CP0_ASYNC = 9;
  localparam int SIG_CP1 = 10;
  localparam int SIG_CP1_ASYNC = 11;
  localparam int SIG_SYSCLK = 12;
  localparam int SIG_CAPTURE_COMPARE_SIGNAL_0 = 13;
  localparam int NCEX = 5;
  localparam int SIG_ECI = 18;
  localparam int SIG_T0 = 19;
  localparam int SIG_T1 = 20;
  localparam int SIG_U1_TX = 21;
  localparam int SIG_U1_RX = 22;

  // Field positions of route_select_reg_a
  localparam int RA_SERIAL_PORT_FIRST = 0;
  localparam int RA_SPI = 1;
  localparam int RA_SMB = 2;
  localparam int RA_SYSCLK = 3;
  localparam int RA_CP0 = 4;
  localparam int RA_CP0_ASYNC = 5;
  localparam int RA_CP1 = 6;
  localparam int RA_CP1_ASYNC = 7;
  // Field positions of route_select_reg_b
  localparam int RB_CEX_LO = 0;
  localparam int RB_ECI = 3;
  localparam int RB_T0 = 4;
  localparam int RB_T1 = 5;
  localparam int RB_XBAR_EN = 6;
  localparam int RB_PUD = 7;
  // Field position of route_select_reg_c
  localparam int RC_UART1 = 0;

  localparam logic [2:0] CEX_MAX_CODE = 3'h5;
  localparam logic [1:0] SPI_MODE_3WIRE = 2'h0;
  localparam logic [NXPIN-1:0] U0_TX_MASK = 32'h0000_0010;
  localparam logic [NXPIN-1:0] U0_RX_MASK = 32'h0000_0020;

  // Register select codes of the configuration port
  localparam logic [REG_SEL_W-1:0] REG_ROUTE_A = 5'h00;
  localparam logic [REG_SEL_W-1:0] REG_ROUTE_B = 5'h01;
  localparam logic [REG_SEL_W-1:0] REG_ROUTE_C = 5'h02;
  localparam logic [REG_SEL_W-1:0] REG_SKIP0 = 5'h03;
  localparam logic [REG_SEL_W-1:0] REG_MDIN0 = 5'h07;
  localparam logic [REG_SEL_W-1:0] REG_MDOUT0 = 5'h0c;
  localparam logic [REG_SEL_W-1:0] REG_LATCH0 = 5'h11;
  localparam logic [REG_SEL_W-1:0] REG_LATCH4 = 5'h15;

  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
endpackage

// File: src/pcxb_slot.sv
// One crossbar slot: grants the lowest pin not yet taken
`timescale 1ns/1ps
module pcxb_slot #(
  parameter int W = 32
) (
  input wire logic req,
  input wire logic [W-1:0] taken_in,
  output logic [W-1:0] grant,
  output logic [W-1:0] taken_out
);
  wire [W-1:0] free = ~taken_in;
  wire [W-1:0] lowest = free & (~free + {{(W-1){1'b0}}, 1'b1});

  assign grant = req ? lowest : {W{1'b0}};
  assign taken_out = taken_in | grant;
endmodule

// File: src/pcxb_pin_cell.sv
// Driver, open-drain and weak pull-up logic of one port pin
`timescale 1ns/1ps
module pcxb_pin_cell (
  input wire logic use_periph,
  input wire logic periph_val,
  input wire logic periph_drive,
  input wire logic latch_val,
  input wire logic digital,
  input wire logic push_pull,
  input wire logic force_od,
  input wire logic pud,
  input wire logic drv_allow,
  output logic out_val,
  output logic oe,
  output logic pull_en
);
  wire val = use_periph ? periph_val : latch_val;
  wire want = use_periph ? periph_drive : 1'b1;
  wire od = force_od | ~push_pull;
  wire active = digital & drv_allow & want;

  // Open drain only ever pulls low; a latched 1 leaves the pin undriven, on its pull-up unless pull-ups are disabled
  assign oe = active & (od ? ~val : 1'b1);
  assign out_val = od ? 1'b0 : val;
  // Pull-up only on digital open-drain pins, and off while pulling low
  assign pull_en = digital & od & ~pud & ~(oe & ~out_val);
endmodule

// File: src/pcxb_crossbar.sv
// Priority crossbar with per-pin mode, skip, pull-up and latch control
`timescale 1ns/1ps
module pcxb_crossbar (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cfg_wr_en,
  input wire logic [pcxb_pkg::REG_SEL_W-1:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  input wire logic [pcxb_pkg::REG_SEL_W-1:0] rd_sel,
  input wire logic rd_rmw,
  output logic [7:0] rd_data,
  input wire logic [1:0] spi_select_mode_field,
  input wire logic [pcxb_pkg::NSIG-1:0] periph_out,
  input wire logic [pcxb_pkg::NSIG-1:0] periph_oe,
  output logic [pcxb_pkg::NSIG-1:0] periph_in,
  input wire logic [pcxb_pkg::NPIN-1:0] pin_in,
  output logic [pcxb_pkg::NPIN-1:0] pin_out,
  output logic [pcxb_pkg::NPIN-1:0] pin_oe,
  output logic [pcxb_pkg::NPIN-1:0] pin_pullup,
  output logic [pcxb_pkg::NPIN-1:0] pin_rx_en,
  output logic [pcxb_pkg::NXPIN-1:0] pin_assigned
);
  import pcxb_pkg::*;

  logic [7:0] cfg_ff [NREG];
  logic [NPIN-1:0] pin_meta_ff;
  logic [NPIN-1:0] pin_sync_ff;
  logic [NPIN-1:0] pin_out_ff;
  logic [NPIN-1:0] pin_oe_ff;
  logic [NPIN-1:0] pin_pullup_ff;
  logic [NXPIN-1:0] pin_assigned_ff;
  logic [NSIG-1:0] periph_in_ff;
  logic [7:0] rd_data_ff;

  // Configuration registers; input mode and latches reset to all ones
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    localparam logic [7:0] RST_VAL =
      ((r >= int'(REG_MDIN0) && r < int'(REG_MDOUT0)) || r >= int'(REG_LATCH0)) ?
      RST_ONES : RST_ZERO;
    wire wr_hit = cfg_wr_en && (cfg_sel == REG_SEL_W'(r));
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        cfg_ff[r] <= RST_VAL;
      end else if (wr_hit) begin
        cfg_ff[r] <= cfg_wdata;
      end
    end
  end

  // Pins come from outside: two flops before any logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  logic [NXPIN-1:0] skip_vec;
  logic [NPIN-1:0] mdin_vec;
  logic [NPIN-1:0] mdout_vec;
  logic [NPIN-1:0] latch_vec;
  for (genvar p = 0; p < NPORT; p++) begin : g_vec
    assign mdin_vec[8*p +: 8] = cfg_ff[int'(REG_MDIN0) + p];
    assign mdout_vec[8*p +: 8] = cfg_ff[int'(REG_MDOUT0) + p];
    assign latch_vec[8*p +: 8] = cfg_ff[int'(REG_LATCH0) + p];
    if (p < NPORT - 1) begin : g_skip
      assign skip_vec[8*p +: 8] = cfg_ff[int'(REG_SKIP0) + p];
    end
  end

  wire [7:0] route_a = cfg_ff[REG_ROUTE_A];
  wire [7:0] route_b = cfg_ff[REG_ROUTE_B];
  wire [7:0] route_c = cfg_ff[REG_ROUTE_C];
  wire crossbar_enable_bit = route_b[RB_XBAR_EN];
  wire pullup_disable_bit = route_b[RB_PUD];
  wire [2:0] counter_array_pin_enable = route_b[RB_CEX_LO +: 3];
  wire spi_four_wire = spi_select_mode_field != SPI_MODE_3WIRE;
  wire cex_code_ok = counter_array_pin_enable <= CEX_MAX_CODE;

  // Peripheral requests in priority order
  logic [NSIG-1:0] req;
  assign req[SIG_U0_TX] = route_a[RA_SERIAL_PORT_FIRST];
  assign req[SIG_U0_RX] = route_a[RA_SERIAL_PORT_FIRST];
  assign req[SIG_SPI_SCK] = route_a[RA_SPI];
  assign req[SIG_SPI_MISO] = route_a[RA_SPI];
  assign req[SIG_SPI_MOSI] = route_a[RA_SPI];
  assign req[SIG_SPI_NSS] = route_a[RA_SPI] & spi_four_wire;
  assign req[SIG_SMB_SDA] = route_a[RA_SMB];
  assign req[SIG_SMB_SCL] = route_a[RA_SMB];
  assign req[SIG_CP0] = route_a[RA_CP0];
  assign req[SIG_CP0_ASYNC] = route_a[RA_CP0_ASYNC];
  assign req[SIG_CP1] = route_a[RA_CP1];
  assign req[SIG_CP1_ASYNC] = route_a[RA_CP1_ASYNC];
  assign req[SIG_SYSCLK] = route_a[RA_SYSCLK];
  for (genvar k = 0; k < NCEX; k++) begin : g_cex
    // Reserved codes route no compare signal
    assign req[SIG_CAPTURE_COMPARE_SIGNAL_0 + k] = cex_code_ok && (counter_array_pin_enable > 3'(k));
  end
  assign req[SIG_ECI] = route_b[RB_ECI];
  assign req[SIG_T0] = route_b[RB_T0];
  assign req[SIG_T1] = route_b[RB_T1];
  assign req[SIG_U1_TX] = route_c[RC_UART1];
  assign req[SIG_U1_RX] = route_c[RC_UART1];

  // First serial port sits on fixed pins whatever the skip bits say
  logic [NXPIN-1:0] grant [NSIG];
  wire [NXPIN-1:0] serial_port_first_mask = req[SIG_U0_TX] ? (U0_TX_MASK | U0_RX_MASK) : '0;
  assign grant[SIG_U0_TX] = req[SIG_U0_TX] ? U0_TX_MASK : '0;
  assign grant[SIG_U0_RX] = req[SIG_U0_RX] ? U0_RX_MASK : '0;

  // Priority scan: each slot sees pins taken by all higher slots
  logic [NXPIN-1:0] taken [SIG_SPI_SCK:NSIG];
  assign taken[SIG_SPI_SCK] = skip_vec | serial_port_first_mask;
  logic [NSIG-1:0] bad_low;
  assign bad_low[SIG_SPI_SCK-1:0] = '0;
  for (genvar s = SIG_SPI_SCK; s < NSIG; s++) begin : g_slot
    pcxb_slot #(.W(NXPIN)) u_slot (
      .req(req[s]),
      .taken_in(taken[s]),
      .grant(grant[s]),
      .taken_out(taken[s+1])
    );
    assign bad_low[s] = (|grant[s]) &
      (|((grant[s] - 32'h0000_0001) & ~taken[s]));
  end

  // Per-pin view of the grants, only pins 0..31 take peripherals
  logic [NSIG-1:0] col [NXPIN];
  logic [NXPIN-1:0] pin_valid;
  logic [NXPIN-1:0] pin_pval;
  logic [NXPIN-1:0] pin_poe;
  logic [NXPIN-1:0] pin_smb;
  logic [NXPIN-1:0] overlap;
  for (genvar i = 0; i < NXPIN; i++) begin : g_col
    for (genvar s = 0; s < NSIG; s++) begin : g_bit
      assign col[i][s] = grant[s][i];
    end
    assign pin_valid[i] = crossbar_enable_bit & (|col[i]);
    assign pin_pval[i] = |(col[i] & periph_out);
    assign pin_poe[i] = |(col[i] & periph_oe);
    assign pin_smb[i] = pin_valid[i] & (col[i][SIG_SMB_SDA] | col[i][SIG_SMB_SCL]);
    assign overlap[i] = !$onehot0(col[i]);
  end

  // Pin levels as seen by software and peripherals; analog pins read 0
  wire [NPIN-1:0] pin_lvl = pin_sync_ff & mdin_vec;

  logic [NSIG-1:0] nxt_periph_in;
  for (genvar s = 0; s < NSIG; s++) begin : g_pin_in
    wire routed = crossbar_enable_bit & (|grant[s]);
    // Unrouted peripheral inputs idle high
    assign nxt_periph_in[s] = routed ? |(grant[s] & pin_lvl[NXPIN-1:0]) : 1'b1;
  end

  logic [NPIN-1:0] nxt_pin_out;
  logic [NPIN-1:0] nxt_pin_oe;
  logic [NPIN-1:0] nxt_pin_pullup;
  for (genvar i = 0; i < NPIN; i++) begin : g_cell
    wire xbar_pin = (i < NXPIN);
    wire use_p;
    wire p_val;
    wire p_drv;
    wire p_smb;
    if (i < NXPIN) begin : g_x
      assign use_p = pin_valid[i];
      assign p_val = pin_pval[i];
      assign p_drv = pin_poe[i];
      assign p_smb = pin_smb[i];
    end else begin : g_g
      assign use_p = 1'b0;
      assign p_val = 1'b0;
      assign p_drv = 1'b0;
      assign p_smb = 1'b0;
    end
    pcxb_pin_cell u_cell (
      .use_periph(use_p),
      .periph_val(p_val),
      .periph_drive(p_drv),
      .latch_val(latch_vec[i]),
      .digital(mdin_vec[i]),
      .push_pull(mdout_vec[i]),
      .force_od(p_smb),
      .pud(pullup_disable_bit),
      .drv_allow(xbar_pin ? crossbar_enable_bit : 1'b1),
      .out_val(nxt_pin_out[i]),
      .oe(nxt_pin_oe[i]),
      .pull_en(nxt_pin_pullup[i])
    );
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      pin_pullup_ff <= '0;
      pin_assigned_ff <= '0;
      periph_in_ff <= '1;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pin_pullup_ff <= nxt_pin_pullup;
      pin_assigned_ff <= pin_valid;
      periph_in_ff <= nxt_periph_in;
    end
  end

  // Register read: port bytes show pins, unless read-modify-write
  logic [7:0] pin_byte [NPORT];
  for (genvar p = 0; p < NPORT; p++) begin : g_byte
    assign pin_byte[p] = pin_lvl[8*p +: 8];
  end
  wire rd_mapped = int'(rd_sel) < NREG;
  wire rd_is_latch = (rd_sel >= REG_LATCH0) && (rd_sel <= REG_LATCH4);
  wire [REG_SEL_W-1:0] rd_off = rd_sel - REG_LATCH0;
  wire [7:0] nxt_rd_data =
    !rd_mapped ? 8'h00 :
    (rd_is_latch && !rd_rmw) ? pin_byte[rd_off[2:0]] :
    cfg_ff[rd_sel];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;
  assign periph_in = periph_in_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign pin_pullup = pin_pullup_ff;
  assign pin_rx_en = mdin_vec;
  assign pin_assigned = pin_assigned_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_xbar_off;
    !crossbar_enable_bit;
  endsequence
  sequence s_serial_port_first_on;
    crossbar_enable_bit && req[SIG_U0_TX];
  endsequence
  sequence s_latch_pin_read;
    rd_is_latch && !rd_rmw;
  endsequence
  sequence s_latch_rmw_read;
    rd_is_latch && rd_rmw;
  endsequence

  a_xbar_off_idle: assert property (
    s_xbar_off |=> (pin_oe_ff[NXPIN-1:0] == '0) && (pin_assigned_ff == '0))
    else $error("crossbar disabled but port 0-3 pin driven or assigned");
  a_port4_gpio: assert property (
    1'b1 |=> pin_oe_ff[NPIN-1:NXPIN] == $past(mdin_vec[NPIN-1:NXPIN] &
      (mdout_vec[NPIN-1:NXPIN] | ~latch_vec[NPIN-1:NXPIN])))
    else $error("port 4 driver does not follow its latch and modes");
  a_uart_fixed: assert property (
    s_serial_port_first_on |-> col[4][SIG_U0_TX] && col[5][SIG_U0_RX] && pin_valid[5:4] == 2'h3)
    else $error("first serial port not on its fixed pins");
  a_skip_kept: assert property (
    crossbar_enable_bit |-> (pin_valid & skip_vec & ~serial_port_first_mask) == '0)
    else $error("skipped pin received a crossbar signal");
  a_no_overlap: assert property (
    overlap == '0)
    else $error("pin granted to more than one signal");
  a_lowest_free: assert property (
    bad_low == '0)
    else $error("signal skipped a lower free pin");
  a_nss_mode: assert property (
    !spi_four_wire |-> grant[SIG_SPI_NSS] == '0)
    else $error("slave select routed in 3-wire mode");
  a_cex_reserved: assert property (
    !cex_code_ok |-> req[SIG_CAPTURE_COMPARE_SIGNAL_0 +: NCEX] == '0)
    else $error("reserved counter code routed a compare signal");
  a_analog_quiet: assert property (
    1'b1 |=> ((pin_oe_ff | pin_pullup_ff) & ~$past(mdin_vec)) == '0)
    else $error("analog pin has driver or pull-up on");
  a_smbus_od: assert property (
    1'b1 |=> (pin_oe_ff[NXPIN-1:0] & pin_out_ff[NXPIN-1:0] & $past(pin_smb)) == '0)
    else $error("SMBus pin driven high");
  a_pullup_low: assert property (
    (pin_oe_ff & ~pin_out_ff & pin_pullup_ff) == '0)
    else $error("pull-up on while pin drives low");
  a_pin_read: assert property (
    s_latch_pin_read |=> rd_data ==
      8'(($past(pin_sync_ff) & $past(mdin_vec)) >> (8 * $past(rd_off[2:0]))))
    else $error("port read did not return the pin level");
  a_rmw_latch: assert property (
    s_latch_rmw_read |=> rd_data == 8'($past(latch_vec >> (8 * rd_off[2:0]))))
    else $error("read-modify-write did not return the latch");
  // Pull-up, idle input and driver checks one edge after the settings; reset check in the cycle reset is released
  a_pud_off: assert property (
    pullup_disable_bit |=> pin_pullup_ff == '0)
    else $error("pull-up on while pull-ups disabled");
  a_pp_no_pullup: assert property (
    1'b1 |=> (pin_pullup_ff & $past(mdout_vec & ~{8'h00, pin_smb})) == '0)
    else $error("push-pull pin has its pull-up on");
  a_od_no_high: assert property (
    1'b1 |=> (pin_oe_ff & pin_out_ff & ~$past(mdout_vec)) == '0)
    else $error("open-drain pin driven high");
  a_gpio_latch: assert property (
    crossbar_enable_bit |=> ((pin_out_ff[NXPIN-1:0] ^ $past(latch_vec[NXPIN-1:0])) &
      $past(~pin_valid & mdin_vec[NXPIN-1:0] & mdout_vec[NXPIN-1:0])) == '0)
    else $error("general purpose pin does not follow its latch");
  a_idle_inputs: assert property (
    s_xbar_off |=> periph_in_ff == '1)
    else $error("peripheral input not idle while crossbar disabled");
  a_reset_digital: assert property (
    $rose(rst_b) |-> (mdin_vec == '1) && (pin_oe_ff == '0))
    else $error("pins not digital inputs after reset");
endmodule

// File: tb/pcxb_ext_pins.sv
// Board circuitry on the package pins: resolves each pin level
`timescale 1ns/1ps
module pcxb_ext_pins (
  input wire logic clk,
  input wire logic [pcxb_pkg::NPIN-1:0] pin_out,
  input wire logic [pcxb_pkg::NPIN-1:0] pin_oe,
  input wire logic [pcxb_pkg::NPIN-1:0] pin_pullup,
  input wire logic [pcxb_pkg::NPIN-1:0] ext_en,
  input wire logic [pcxb_pkg::NPIN-1:0] ext_val,
  output logic [pcxb_pkg::NPIN-1:0] pin_level
);
  import pcxb_pkg::*;
  logic flt_ff = 1'b0;
  // A floating pin toggles every cycle so no stale level can be read back
  always_ff @(posedge clk) begin
    flt_ff <= ~flt_ff;
  end
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | {NPIN{flt_ff}}));
endmodule

// File: tb/priority_crossbar_port_config_tb.sv
// Self-checking bench for the priority crossbar port configuration block
`timescale 1ns/1ps
module priority_crossbar_port_config_tb;
  import pcxb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_wr_en = 1'b0;
  logic [REG_SEL_W-1:0] cfg_sel = '0;
  logic [7:0] cfg_wdata = '0;
  logic [REG_SEL_W-1:0] rd_sel = '0;
  logic rd_rmw = 1'b0;
  logic [7:0] rd_data;
  logic [1:0] spi_select_mode_field = 2'h0;
  logic [NSIG-1:0] periph_out = '0;
  logic [NSIG-1:0] periph_oe = '0;
  logic [NSIG-1:0] periph_in;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] pin_out;
  logic [NPIN-1:0] pin_oe;
  logic [NPIN-1:0] pin_pullup;
  logic [NPIN-1:0] pin_rx_en;
  logic [NXPIN-1:0] pin_assigned;
  logic [NPIN-1:0] ext_en = '0;
  logic [NPIN-1:0] ext_val = '0;
  logic [7:0] rv;
  int error_cnt = 0;
  int tests_run = 0;

  pcxb_crossbar i_pcxb_crossbar (.clk(clk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en),
    .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .rd_sel(rd_sel), .rd_rmw(rd_rmw),
    .rd_data(rd_data), .spi_select_mode_field(spi_select_mode_field),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .pin_rx_en(pin_rx_en), .pin_assigned(pin_assigned));

  pcxb_ext_pins i_pcxb_ext_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [REG_SEL_W-1:0] sel, input logic [7:0] data);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_sel <= sel;
    cfg_wdata <= data;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [REG_SEL_W-1:0] sel, input logic rmw);
    @(posedge clk);
    rd_sel <= sel;
    rd_rmw <= rmw;
    repeat (2) @(posedge clk);
    #1 rv = rd_data;
  endtask

  // Covers the one-edge output latency and the two-flop pin synchroniser
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("wrong value run time expected done seen hung");
    give_verdict();
  end

  initial begin
    int n;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("rx_en", pin_rx_en, '1);
    chk("oe", pin_oe, '0);
    chk("pullup", pin_pullup, '1);
    chk("assigned", 40'(pin_assigned), '0);
    rd(REG_MDIN0, 1'b0);
    chk("mdin0", 40'(rv), 40'hff);
    rd(REG_LATCH0, 1'b1);
    chk("latch0", 40'(rv), 40'hff);
    rd(5'h1f, 1'b0);
    chk("unmapped", 40'(rv), '0);
    $display("test reset done");

    wr(REG_MDOUT0, 8'hc8);
    wr(REG_LATCH0, 8'h7f);
    wr(REG_ROUTE_A, 8'h07);
    wr(REG_ROUTE_B, 8'h40);
    periph_oe <= NSIG'(1 << SIG_U0_TX | 1 << SIG_SMB_SDA | 1 << SIG_SMB_SCL);
    periph_out <= NSIG'(1 << SIG_SMB_SCL);
    ext_en <= 40'h20;
    settle();
    chk("assigned", 40'(pin_assigned), 40'h7f);
    chk("oe p0", 40'(pin_oe[7:0]), 40'h98);
    chk("out p0", 40'(pin_out[7:0]), 40'h00);
    chk("pullup p0", 40'(pin_pullup[7:0]), 40'h67);
    chk("rx in", 40'(periph_in[SIG_U0_RX]), '0);
    $display("test routing done");

    spi_select_mode_field <= 2'h1;
    wr(REG_SKIP0, 8'h03);
    wr(REG_ROUTE_A, 8'h03);
    settle();
    chk("assigned", 40'(pin_assigned), 40'hfc);
    $display("test skip done");

    wr(5'(REG_MDOUT0 + 5'h4), 8'hff);
    wr(REG_LATCH4, 8'h00);
    wr(REG_ROUTE_B, 8'h00);
    settle();
    chk("assigned", 40'(pin_assigned), '0);
    chk("oe", pin_oe, 40'hff_0000_0000);
    chk("periph_in", 40'(periph_in), 40'h7f_ffff);
    $display("test disable done");

    wr(REG_MDIN0, 8'hfe);
    wr(REG_ROUTE_B, 8'h40);
    settle();
    chk("rx_en p0", 40'(pin_rx_en[7:0]), 40'hfe);
    chk("pullup pin0", 40'(pin_pullup[0]), '0);
    chk("oe pin0", 40'(pin_oe[0]), '0);
    rd(REG_LATCH0, 1'b0);
    chk("read pin0", 40'(rv[0]), '0);
    wr(REG_ROUTE_B, 8'hc0);
    settle();
    chk("pullup", pin_pullup, '0);
    $display("test analog done");

    wr(REG_ROUTE_B, 8'h40);
    wr(5'(REG_LATCH0 + 5'h1), 8'h0f);
    ext_en <= 40'h120;
    settle();
    chk("oe p1", 40'(pin_oe[15:8]), 40'hf0);
    rd(5'(REG_LATCH0 + 5'h1), 1'b0);
    chk("p1 pins", 40'(rv), 40'h0e);
    rd(5'(REG_LATCH0 + 5'h1), 1'b1);
    chk("p1 latch", 40'(rv), 40'h0f);
    rd(REG_LATCH0, 1'b0);
    chk("read pin5", 40'(rv[5]), '0);
    $display("test port read done");

    @(posedge clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("assigned", 40'(pin_assigned), '0);
    chk("rx_en", pin_rx_en, '1);
    wr(REG_ROUTE_C, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(REG_ROUTE_B, 8'h78 | 8'(c));
      settle();
      n = (c <= 5) ? c : 0;
      chk("assigned", 40'(pin_assigned), (40'h1 << (n + 5)) - 40'h1);
    end
    $display("test counter field done");
    give_verdict();
  end
endmodule
